// [src/daq_io_sequencer.v]
`timescale 1ns/1ns
`include "daq_io_consts.vh"
// Notes on behaviour
// (R1) One converter; exactly one selected channel routed to the gain stage.
// (R2) Differential gain chosen from 1, 2, 4, 5, 8, 10, 16, 20.
// (R3) Single-ended channels always use gain 1.
// (R4) Gain derived from selected range; never written directly.
// (R5) Single, fixed-count and continuous acquisition runs.
// (R6) Samples go through a FIFO and are read back in order.
// (R7) Each channel selectable single-ended or differential.
// (R8) Differential pairs are channel n with channel n plus four.
// (R9) Armed trigger holds conversions until chosen edge on trigger pin.
// (R10) Trigger pin is either start trigger or counter source.
// (R11) Two independent analog outputs change only on host writes.
// (R12) Twelve lines, eight low and four high, each direction programmable.
// (R13) Outputs default to open drain, only pulling low.
// (R14) Push-pull drive selectable per line on the capable variant.
// (R15) Reset makes every line an input with driver off.
// (R16) Digital sampling and updates only on individual host accesses.
// (R17) Counter counts falling edges of the trigger pin, 32 bits.
// (R18) Counter clears at count start and wraps without stopping.
// (R19) Auxiliary supply disabled during suspend, enabled on resume.
// (R20) Full buffer during acquisition sets sticky readable overflow flag.
module daq_io_sequencer #(
  parameter PUSHPULL_CAPABLE = `PUSHPULL_OK
) (
  // Clock and reset.
  input  wire                 clk_sys,
  input  wire                 rst_n,
  // AXI4-Lite write channels.
  input  wire [7:0]           s_axi_awaddr,
  input  wire                 s_axi_awvalid,
  output reg                  s_axi_awready,
  input  wire [31:0]          s_axi_wdata,
  input  wire [3:0]           s_axi_wstrb,
  input  wire                 s_axi_wvalid,
  output reg                  s_axi_wready,
  output reg  [1:0]           s_axi_bresp,
  output reg                  s_axi_bvalid,
  input  wire                 s_axi_bready,
  // AXI4-Lite read channels.
  input  wire [7:0]           s_axi_araddr,
  input  wire                 s_axi_arvalid,
  output reg                  s_axi_arready,
  output reg  [31:0]          s_axi_rdata,
  output reg  [1:0]           s_axi_rresp,
  output reg                  s_axi_rvalid,
  input  wire                 s_axi_rready,
  // Converter.
  output reg                  convStart,
  input  wire                 convDone,
  input  wire [`SAMPLE_W-1:0] convData,
  output reg  [2:0]           muxPos,
  output reg  [2:0]           muxNeg,
  output reg                  muxNegEnable,
  output reg  [2:0]           gainCode,
  // Analog output codes.
  output reg  [11:0]          aout0Code,
  output reg  [11:0]          aout1Code,
  // Digital port and trigger pin.
  input  wire [7:0]           port_low_lines_in,
  input  wire [3:0]           port_high_lines_in,
  output reg  [`DIO_LINES-1:0] dioOut,
  output reg  [`DIO_LINES-1:0] dioOe,
  input  wire                 trigger_count_input,
  // Power.
  input  wire                 usbSuspend,
  output reg                  auxSupplyEn
);
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_ARM  = 4'h2;
  localparam [3:0] ST_CONV = 4'h4;
  localparam [3:0] ST_WAIT = 4'h8;
  reg        rstMeta_reg;
  reg        rstSync_reg;
  reg  [3:0] state_reg;
  reg  [1:0] mode_reg;
  reg        trigEn_reg;
  reg        trigFall_reg;
  reg        pinCount_reg;
  reg  [7:0] chan_reg;
  reg  [31:0] count_reg;
  reg  [31:0] remain_reg;
  reg        ovf_reg;
  reg  [`DIO_LINES-1:0] dir_reg;
  reg  [`DIO_LINES-1:0] pp_reg;
  reg  [`DIO_LINES-1:0] dout_reg;
  reg  [31:0] evCount_reg;
  reg        pinPrev_reg;
  reg        awHeld_reg;
  reg        wHeld_reg;
  reg  [7:0] awAddr_reg;
  reg  [31:0] wData_reg;
  reg        fifoTake_reg;
  wire       fifoReady;
  wire       fifoValid;
  wire [`SAMPLE_W-1:0] fifoData;
  wire       doWrite;
  wire       doRead;
  wire       pinRise;
  wire       pinFall;
  wire       ctlWrite;
  wire [7:0] wa;
  wire [31:0] wd;

  // Range code 0..7 maps to gains 1,2,4,5,8,10,16,20 in differential mode.
  function [2:0] gainFor;
    input [7:0] ch;
    gainFor = ch[`CHAN_DIFF] ? ch[`CHAN_RANGE_HI:`CHAN_RANGE_LO] : 3'h0;
  endfunction

  sample_fifo fifo (
    .clk       (clk_sys),
    .rstSync_n (rstSync_reg),
    .wrValid   (convDone && state_reg == ST_WAIT),
    .wrData    (convData),
    .wrReady   (fifoReady),
    .rdTake    (fifoTake_reg),
    .rdData    (fifoData),
    .rdValid   (fifoValid)
  );
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end
  assign doWrite  = awHeld_reg && wHeld_reg && !s_axi_bvalid;
  assign doRead   = s_axi_arvalid && s_axi_arready;
  assign ctlWrite = doWrite && awAddr_reg == `ADDR_CTRL;
  assign wa       = awAddr_reg;
  assign wd       = wData_reg;
  assign pinRise  = trigger_count_input && !pinPrev_reg;
  assign pinFall  = !trigger_count_input && pinPrev_reg;

  always @(posedge clk_sys or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `RESP_OKAY;
      s_axi_rdata   <= 32'h0;
      awHeld_reg <= 1'b0;
      wHeld_reg  <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg  <= 32'h0;
      state_reg  <= ST_IDLE;
      mode_reg   <= `MODE_SINGLE;
      trigEn_reg <= 1'b0;
      trigFall_reg <= 1'b0;
      pinCount_reg <= 1'b0;
      chan_reg   <= 8'h00;
      count_reg  <= 32'h1;
      remain_reg <= 32'h0;
      ovf_reg    <= 1'b0;
      dir_reg    <= {`DIO_LINES{1'b0}};
      pp_reg     <= {`DIO_LINES{1'b0}};
      dout_reg   <= {`DIO_LINES{1'b0}};
      evCount_reg <= 32'h0;
      pinPrev_reg <= 1'b1;
      fifoTake_reg <= 1'b0;
      convStart  <= 1'b0;
      aout0Code  <= 12'h000;
      aout1Code  <= 12'h000;
      auxSupplyEn <= 1'b0;
    end else begin
      fifoTake_reg  <= 1'b0;
      convStart     <= 1'b0;
      pinPrev_reg   <= trigger_count_input;
      // Write path: address and data may arrive in either order.
      s_axi_awready <= !awHeld_reg && !s_axi_awready && s_axi_awvalid &&
                       !s_axi_bvalid;
      s_axi_wready  <= !wHeld_reg && !s_axi_wready && s_axi_wvalid &&
                       !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (doWrite) begin
        awHeld_reg   <= 1'b0;
        wHeld_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RESP_OKAY;
        if (wa == `ADDR_CTRL) begin
          mode_reg     <= wd[`CTRL_MODE_HI:`CTRL_MODE_LO];
          trigEn_reg   <= wd[`CTRL_TRIG_EN];
          trigFall_reg <= wd[`CTRL_TRIG_FALL];
          // (R10) One pin function
          pinCount_reg <= wd[`CTRL_PIN_COUNT];
          if (wd[`CTRL_START] && state_reg == ST_IDLE) begin
            // (R9) Arm trigger
            state_reg  <= (wd[`CTRL_TRIG_EN] && !wd[`CTRL_PIN_COUNT]) ?
                          ST_ARM : ST_CONV;
            remain_reg <= (wd[`CTRL_MODE_HI:`CTRL_MODE_LO] == `MODE_MULTI)
                          ? count_reg : 32'h1;
          end
        end else if (wa == `ADDR_CHAN) begin
          // (R7) Mode select
          chan_reg <= wd[7:0];
        end else if (wa == `ADDR_COUNT) begin
          count_reg <= wd;
        end else if (wa == `ADDR_AOUT0) begin
          // (R11) Host update only
          aout0Code <= wd[11:0];
        end else if (wa == `ADDR_AOUT1) begin
          aout1Code <= wd[11:0];
        end else if (wa == `ADDR_DIR) begin
          // (R12) Per-line direction
          dir_reg <= wd[`DIO_LINES-1:0];
        end else if (wa == `ADDR_PUSHPULL) begin
          // (R14) Push-pull option
          pp_reg <= PUSHPULL_CAPABLE ? wd[`DIO_LINES-1:0]
                                     : {`DIO_LINES{1'b0}};
        end else if (wa == `ADDR_DOUT) begin
          // (R16) Software-timed output
          dout_reg <= wd[`DIO_LINES-1:0];
        end else if (wa != `ADDR_STATUS) begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (doRead) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        s_axi_rdata  <= 32'h0;
        if (s_axi_araddr == `ADDR_CTRL) begin
          s_axi_rdata <= {25'h0, pinCount_reg, trigFall_reg, trigEn_reg,
                          mode_reg, 2'h0};
        end else if (s_axi_araddr == `ADDR_STATUS) begin
          s_axi_rdata <= {27'h0, !fifoReady, !fifoValid, ovf_reg,
                          state_reg == ST_ARM, state_reg != ST_IDLE};
        end else if (s_axi_araddr == `ADDR_CHAN) begin
          s_axi_rdata <= {24'h0, chan_reg};
        end else if (s_axi_araddr == `ADDR_COUNT) begin
          s_axi_rdata <= count_reg;
        end else if (s_axi_araddr == `ADDR_FIFO) begin
          // (R6) In-order readout
          s_axi_rdata  <= {15'h0, fifoValid, fifoData};
          fifoTake_reg <= fifoValid;
        end else if (s_axi_araddr == `ADDR_AOUT0) begin
          s_axi_rdata <= {20'h0, aout0Code};
        end else if (s_axi_araddr == `ADDR_AOUT1) begin
          s_axi_rdata <= {20'h0, aout1Code};
        end else if (s_axi_araddr == `ADDR_DIR) begin
          s_axi_rdata <= {20'h0, dir_reg};
        end else if (s_axi_araddr == `ADDR_PUSHPULL) begin
          s_axi_rdata <= {20'h0, pp_reg};
        end else if (s_axi_araddr == `ADDR_DOUT) begin
          s_axi_rdata <= {20'h0, dout_reg};
        end else if (s_axi_araddr == `ADDR_DIN) begin
          // (R16) Software-timed sample
          s_axi_rdata <= {20'h0, port_high_lines_in, port_low_lines_in};
        end else if (s_axi_araddr == `ADDR_EVCOUNT) begin
          s_axi_rdata <= evCount_reg;
        end else begin
          s_axi_rresp <= `RESP_SLVERR;
        end
      end
      // (R17) Falling-edge count; (R18) clear at start, free wrap.
      if (ctlWrite && wd[`CTRL_CNT_START]) begin
        evCount_reg <= 32'h0;
      end else if (pinCount_reg && pinFall) begin
        evCount_reg <= evCount_reg + 32'h1;
      end
      // (R5) Acquisition sequencing
      case (state_reg)
        ST_ARM: begin
          // (R9) Edge wait
          if (trigFall_reg ? pinFall : pinRise) begin
            state_reg <= ST_CONV;
          end
        end
        ST_CONV: begin
          convStart <= 1'b1;
          state_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          if (convDone) begin
            remain_reg <= remain_reg - 32'h1;
            state_reg  <= (mode_reg == `MODE_CONT || remain_reg > 32'h1) ?
                          ST_CONV : ST_IDLE;
          end
        end
        default: begin
        end
      endcase
      // (R5) Host stop
      if (ctlWrite && wd[`CTRL_STOP]) begin
        state_reg <= ST_IDLE;
      end
      // (R20) Sticky overflow
      if (convDone && state_reg == ST_WAIT && !fifoReady) begin
        ovf_reg <= 1'b1;
      end else if (ctlWrite && wd[`CTRL_OVF_CLR]) begin
        ovf_reg <= 1'b0;
      end
      // (R19) Suspend gating
      auxSupplyEn <= !usbSuspend;
    end
  end

  // (R1) Single route
  always @(posedge clk_sys or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      muxPos       <= 3'h0;
      muxNeg       <= 3'h0;
      muxNegEnable <= 1'b0;
      gainCode     <= 3'h0;
      dioOut       <= {`DIO_LINES{1'b0}};
      dioOe        <= {`DIO_LINES{1'b0}};
    end else begin
      // (R8) Pair n with n+4
      muxPos       <= chan_reg[`CHAN_DIFF] ? {1'b0, chan_reg[1:0]}
                                           : chan_reg[`CHAN_SEL_HI:0];
      muxNeg       <= {1'b1, chan_reg[1:0]};
      muxNegEnable <= chan_reg[`CHAN_DIFF];
      // (R4) Range to gain, forced to unity per (R3), set per (R2).
      gainCode     <= gainFor(chan_reg);
      // (R13) Open drain default, push-pull per (R14); (R15) off at reset.
      dioOut       <= dout_reg & pp_reg;
      dioOe        <= dir_reg & (pp_reg | ~dout_reg);
    end
  end
endmodule // daq_io_sequencer

// [src/daq_io_consts.vh]
`ifndef DAQ_IO_CONSTS_VH
`define DAQ_IO_CONSTS_VH
// Register byte addresses.
`define ADDR_CTRL      8'h00
`define ADDR_STATUS    8'h04
`define ADDR_CHAN      8'h08
`define ADDR_COUNT     8'h0c
`define ADDR_FIFO      8'h10
`define ADDR_AOUT0     8'h14
`define ADDR_AOUT1     8'h18
`define ADDR_DIR       8'h1c
`define ADDR_PUSHPULL  8'h20
`define ADDR_DOUT      8'h24
`define ADDR_DIN       8'h28
`define ADDR_EVCOUNT   8'h2c
// Control register fields.
`define CTRL_START     0
`define CTRL_STOP      1
`define CTRL_MODE_LO   2
`define CTRL_MODE_HI   3
`define CTRL_TRIG_EN   4
`define CTRL_TRIG_FALL 5
`define CTRL_PIN_COUNT 6
`define CTRL_CNT_START 7
`define CTRL_OVF_CLR   8
// Acquisition modes.
`define MODE_SINGLE    2'h0
`define MODE_MULTI     2'h1
`define MODE_CONT      2'h2
// Channel register fields.
`define CHAN_SEL_HI    2
`define CHAN_DIFF      3
`define CHAN_RANGE_LO  4
`define CHAN_RANGE_HI  6
// Status fields.
`define STAT_BUSY      0
`define STAT_WAITTRIG  1
`define STAT_OVF       2
`define STAT_EMPTY     3
`define STAT_FULL      4
// Sizes and reset values.
`define FIFO_DEPTH     256
`define FIFO_AW        8
`define SAMPLE_W       16
`define DIO_LINES      12
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`define PUSHPULL_OK    1'b1
`endif

// [src/sample_fifo.v]
`timescale 1ns/1ns
`include "daq_io_consts.vh"
module sample_fifo (
  // Clock and reset.
  input  wire                  clk,
  input  wire                  rstSync_n,
  // Write side.
  input  wire                  wrValid,
  input  wire [`SAMPLE_W-1:0]  wrData,
  output wire                  wrReady,
  // Read side.
  input  wire                  rdTake,
  output wire [`SAMPLE_W-1:0]  rdData,
  output wire                  rdValid
);
  reg [`SAMPLE_W-1:0] mem [0:`FIFO_DEPTH-1];
  reg [`FIFO_AW:0]    wrPtr_reg;
  reg [`FIFO_AW:0]    rdPtr_reg;
  wire                full;
  wire                empty;
  assign empty   = (wrPtr_reg == rdPtr_reg);
  assign full    = (wrPtr_reg[`FIFO_AW-1:0] == rdPtr_reg[`FIFO_AW-1:0]) &&
                   (wrPtr_reg[`FIFO_AW] != rdPtr_reg[`FIFO_AW]);
  assign wrReady = ~full;
  assign rdValid = ~empty;
  assign rdData  = mem[rdPtr_reg[`FIFO_AW-1:0]];
  always @(posedge clk) begin
    if (wrValid && !full) begin
      mem[wrPtr_reg[`FIFO_AW-1:0]] <= wrData;
    end
  end
  always @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      wrPtr_reg <= {(`FIFO_AW+1){1'b0}};
      rdPtr_reg <= {(`FIFO_AW+1){1'b0}};
    end else begin
      if (wrValid && !full) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (rdTake && !empty) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
    end
  end
endmodule // sample_fifo

// [testbench/daq_io_sequencer_properties.sv]
`timescale 1ns/1ns
module daq_io_checker (
  // Clock and reset.
  input wire        clk_sys,
  input wire        rst_n,
  // Bus responses.
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // Converter, outputs and power.
  input wire        convStart,
  input wire [2:0]  muxPos,
  input wire [2:0]  muxNeg,
  input wire        muxNegEnable,
  input wire [2:0]  gainCode,
  input wire [11:0] aout0Code,
  input wire [11:0] aout1Code,
  input wire [11:0] dioOe,
  input wire        usbSuspend,
  input wire        auxSupplyEn
);
  // Outputs stay cleared just after release, so the supply check waits.
  reg [2:0] age_reg;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      age_reg <= 3'h0;
    else if (age_reg != 3'h7)
      age_reg <= age_reg + 3'h1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_aux_follow:
    assert property (age_reg == 3'h7 |-> auxSupplyEn == !$past(usbSuspend))
    else $error("aux supply not following suspend");
  a_oe_reset:
    assert property (disable iff (1'b0) !rst_n |=> (dioOe == 12'h0) [*2])
    else $error("line driver on during reset");
  a_mux_pair:
    assert property (muxNegEnable |-> !muxPos[2] && muxNeg == muxPos + 3'h4)
    else $error("bad differential pair");
  a_gain_single:
    assert property (!muxNegEnable |-> gainCode == 3'h0)
    else $error("single-ended gain not one");
  a_conv_pulse:
    assert property (convStart |=> !convStart)
    else $error("start pulse too long");
  a_aout_host:
    assert property ((aout0Code != $past(aout0Code) ||
      aout1Code != $past(aout1Code)) |-> $rose(s_axi_bvalid))
    else $error("output code moved without a write");
  a_write_done:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_read_done:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
endmodule // daq_io_checker
bind daq_io_sequencer daq_io_checker u_chk (.clk_sys, .rst_n,
  .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .convStart,
  .muxPos, .muxNeg, .muxNegEnable, .gainCode, .aout0Code, .aout1Code,
  .dioOe, .usbSuspend, .auxSupplyEn);

// [testbench/conv_model.sv]
`timescale 1ns/1ns
module conv_model (
  // Clock and reset.
  input  wire        clk,
  input  wire        rst_n,
  // Request and answer.
  input  wire        start,
  input  wire        slow,
  output reg         done,
  output reg  [15:0] data
);
  reg [2:0]  cnt_reg;
  reg        busy_reg;
  reg [15:0] seq_reg;
  // single busy converter.
  // Data flips outside the done pulse, so a stale sample cannot pass.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done     <= 1'b0;
      data     <= 16'h0;
      busy_reg <= 1'b0;
      cnt_reg  <= 3'h0;
      seq_reg  <= 16'h5a00;
    end else begin
      done <= 1'b0;
      data <= ~data;
      if (start && !busy_reg) begin
        busy_reg <= 1'b1;
        cnt_reg  <= slow ? 3'h6 : 3'h1;
      end else if (busy_reg && cnt_reg != 3'h0) begin
        cnt_reg <= cnt_reg - 3'h1;
      end else if (busy_reg) begin
        busy_reg <= 1'b0;
        done     <= 1'b1;
        data     <= seq_reg;
        seq_reg  <= seq_reg + 16'h1;
      end
    end
  end
endmodule // conv_model

// [testbench/daq_io_sequencer_bench.sv]
`timescale 1ns/1ns
`include "daq_io_consts.vh"
module daq_io_sequencer_bench;
  reg         clk_sys, rst_n, slow, usbSuspend, trigger_count_input, free;
  reg  [7:0]  s_axi_awaddr, s_axi_araddr, port_low_lines_in;
  reg  [3:0]  port_high_lines_in;
  reg  [31:0] s_axi_wdata, r, dir, dout, pp;
  reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg         s_axi_arvalid, s_axi_rready;
  wire [3:0]  s_axi_wstrb = 4'hf;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire        s_axi_rvalid, convStart, convDone, muxNegEnable, auxSupplyEn;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] convData;
  wire [2:0]  muxPos, muxNeg, gainCode;
  wire [11:0] aout0Code, aout1Code, dioOut, dioOe;
  logic [31:0] qd[$], qm[$];
  logic [9:0]  qc[$];
  logic [1:0]  qr[$], qb[$], rsp;
  logic        d;
  logic [2:0]  c, g;
  int          n_mismatch, checks, k, nConv;
  daq_io_sequencer dut (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .convStart, .convDone, .convData, .muxPos, .muxNeg, .muxNegEnable,
    .gainCode, .aout0Code, .aout1Code, .port_low_lines_in, .port_high_lines_in,
    .dioOut, .dioOe, .trigger_count_input, .usbSuspend, .auxSupplyEn);
  conv_model cm (.clk(clk_sys), .rst_n(rst_n), .start(convStart), .slow(slow),
    .done(convDone), .data(convData));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task chk(input logic [31:0] gv, input logic [31:0] ev);
    checks++;
    if (gv !== ev) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, gv, ev);
    end
  endtask
  task wrap_up;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task to(input int n, input int lim);
    if (n >= lim) begin
      chk(n, 32'h0);
      wrap_up;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    logic aw, w;
    @(posedge clk_sys);
    qb.push_back(rsp);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    n = 0;
    while ((aw || w) && n < 999) begin
      @(posedge clk_sys);
      n++;
      if (aw && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_awready) aw = 1'b0;
      if (w && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_wready) w = 1'b0;
    end
    while (!s_axi_bvalid && n < 999) begin
      @(posedge clk_sys);
      n++;
    end
    s_axi_bready <= 1'b0;
    to(n, 999);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    int n;
    @(posedge clk_sys);
    qd.push_back(e & m);
    qm.push_back(m);
    qr.push_back(rsp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!s_axi_arready && n < 999);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid && n < 999) begin
      @(posedge clk_sys);
      n++;
    end
    s_axi_rready <= 1'b0;
    to(n, 999);
  endtask
  task waitn(input int t, input int lim);
    int n;
    n = 0;
    while (nConv < t && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    to(n, lim);
  endtask
  task rdfifo;
    rd(`ADDR_FIFO, {15'h0, 1'b1, 16'h5a00 + k[15:0]}, 32'h1ffff);
    k++;
  endtask
  // Results are matched in arrival order against the notes of the driver.
  always @(posedge clk_sys) begin
    if (convDone) nConv++;
    if (s_axi_rvalid && s_axi_rready && qd.size() > 0) begin
      chk(s_axi_rdata & qm.pop_front(), qd.pop_front());
      chk({30'h0, s_axi_rresp}, {30'h0, qr.pop_front()});
    end
    if (s_axi_bvalid && s_axi_bready && qb.size() > 0)
      chk({30'h0, s_axi_bresp}, {30'h0, qb.pop_front()});
    if (convStart && !free)
      chk({22'h0, muxNegEnable, muxNegEnable ? muxNeg : 3'h0, muxPos,
        gainCode}, qc.size() > 0 ? {22'h0, qc.pop_front()} : 32'hbad);
  end
  initial begin
    {rst_n, slow, usbSuspend, trigger_count_input, free} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {port_low_lines_in, port_high_lines_in} = 12'h0;
    rsp = `RESP_OKAY;
    r = $urandom(32'h3d17);
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk({20'h0, dioOe}, 32'h0);
    rd(`ADDR_STATUS, 32'h8, 32'h1f);
    rd(`ADDR_DIR, 32'h0, 32'hfff);
    usbSuspend <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk({31'h0, auxSupplyEn}, 32'h0);
    usbSuspend <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk({31'h0, auxSupplyEn}, 32'h1);
    $display("reset and suspend done");
    for (int i = 0; i < 10; i++) begin
      d = i < 8;
      c = d ? 3'(i % 4) : 3'(i - 2);
      g = 3'(7 - i % 8);
      slow <= i[0];
      wr(`ADDR_CHAN, {25'h0, g, d, c});
      qc.push_back({d, d ? c + 3'h4 : 3'h0, c, d ? g : 3'h0});
      wr(`ADDR_CTRL, 32'h1);
      waitn(k + 1, 999);
      rdfifo;
    end
    $display("gain and routing done");
    repeat (3) qc.push_back({4'h0, c, 3'h0});
    wr(`ADDR_COUNT, 32'h3);
    wr(`ADDR_CTRL, 32'h5);
    waitn(k + 3, 999);
    repeat (3) rdfifo;
    rd(`ADDR_FIFO, 32'h0, 32'h10000);
    chk(nConv, k);
    $display("multi run done");
    for (int e = 0; e < 2; e++) begin
      trigger_count_input <= e[0];
      qc.push_back({4'h0, c, 3'h0});
      wr(`ADDR_CTRL, 32'h11 | (e << 5));
      rd(`ADDR_STATUS, 32'h2, 32'h2);
      chk(nConv, k);
      trigger_count_input <= !e[0];
      waitn(k + 1, 999);
      rdfifo;
    end
    $display("trigger done");
    free = 1'b1;
    slow <= 1'b0;
    wr(`ADDR_CTRL, 32'h9);
    waitn(k + `FIFO_DEPTH + 4, 20000);
    wr(`ADDR_CTRL, 32'h2);
    rd(`ADDR_STATUS, 32'h14, 32'h14);
    wr(`ADDR_CTRL, 32'h100);
    rd(`ADDR_STATUS, 32'h0, 32'h4);
    repeat (`FIFO_DEPTH) rdfifo;
    rd(`ADDR_FIFO, 32'h0, 32'h10000);
    $display("overflow and drain done");
    trigger_count_input <= 1'b1;
    wr(`ADDR_CTRL, 32'hc0);
    r = $urandom_range(9, 3);
    repeat (r) begin
      trigger_count_input <= 1'b0;
      repeat (3) @(posedge clk_sys);
      trigger_count_input <= 1'b1;
      repeat (3) @(posedge clk_sys);
    end
    rd(`ADDR_EVCOUNT, r, 32'hffffffff);
    r = $urandom;
    wr(`ADDR_AOUT0, r);
    wr(`ADDR_AOUT1, ~r);
    wr(`ADDR_AOUT0, 32'h5);
    repeat (2) @(posedge clk_sys);
    chk({20'h0, aout1Code}, {20'h0, ~r[11:0]});
    chk({20'h0, aout0Code}, 32'h5);
    rsp = `RESP_SLVERR;
    rd(8'h3c, 32'h0, 32'h0);
    wr(8'h3c, 32'h1);
    rsp = `RESP_OKAY;
    $display("counter, outputs and decode done");
    r = $urandom;
    {port_high_lines_in, port_low_lines_in} <= r[11:0];
    rd(`ADDR_DIN, r, 32'hfff);
    for (int j = 0; j < 2; j++) begin
      pp = j ? $urandom : 32'h0;
      dir = $urandom;
      dout = $urandom;
      wr(`ADDR_DIR, dir);
      wr(`ADDR_DOUT, dout);
      wr(`ADDR_PUSHPULL, pp);
      repeat (2) @(posedge clk_sys);
      chk({20'h0, dioOe}, dir & (pp | ~dout) & 32'hfff);
      chk({20'h0, dioOut & dioOe}, dir & pp & dout & 32'hfff);
    end
    rst_n <= 1'b0;
    @(posedge clk_sys);
    chk({20'h0, dioOe}, 32'h0);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rd(`ADDR_DIR, 32'h0, 32'hfff);
    @(posedge clk_sys);
    $display("digital port done");
    wrap_up;
  end
  initial begin
    repeat (90000) @(posedge clk_sys);
    to(1, 1);
  end
endmodule // daq_io_sequencer_bench
